// >>> hw/pcfp_pkg.sv
/*
  pcfp_pkg: shared types and constants for the phase compensation fifo pair.
  assumes a single 100 MHz clock and fabric user logic on the same clock.
*/
package pcfp_pkg;
  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int PCFP_DATA_W = 8;

  typedef struct packed {
    logic ctrl;
    logic [PCFP_DATA_W-1:0] data;
  } pcfp_word_t;

  localparam pcfp_word_t PCFP_WORD_RST = '{ctrl: 1'b0, data: 8'h00};

  // ----------------------------------------
  // buffer occupancy states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCFP_EMPTY = 2'b00,
    PCFP_ONE = 2'b01,
    PCFP_FULL = 2'b10
  } pcfp_fill_t;

  // ----------------------------------------
  // forced and reset values
  // ----------------------------------------
  localparam logic PCFP_SIGDET_FORCED = 1'b1;
  localparam logic PCFP_SIGDET_RST = 1'b0;
endpackage

// >>> hw/pcfp_top.sv
/*
  pcfp_top: receive and transmit phase compensation buffers with fault flags,
  source selection for the fabric side and forced receive signal detection.
  assumes read and write sides share one clock with no frequency offset.
*/
`timescale 1ns/1ns

module pcfp_fifo
  import pcfp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic srst,
  input wire pcfp_pkg::pcfp_word_t in_word,
  input wire logic in_valid,
  output logic in_ready,
  output pcfp_pkg::pcfp_word_t out_word,
  output logic out_valid,
  input wire logic out_ready,
  output logic fault
);
  import pcfp_pkg::*;

  pcfp_fill_t fill_ff, nxt_fill;
  pcfp_word_t head_ff, nxt_head, tail_ff, nxt_tail;
  logic in_ready_ff, nxt_in_ready;
  logic out_valid_ff, nxt_out_valid;
  logic fault_ff, nxt_fault;
  logic push, pop;

  // ----------------------------------------
  // two entry buffer
  // ----------------------------------------
  always_comb
  begin
    push = in_valid && in_ready_ff;
    pop = out_ready && out_valid_ff;
    nxt_fill = fill_ff;
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    unique case (fill_ff)
      PCFP_EMPTY:
      begin
        if (push)
        begin
          nxt_head = in_word;
          nxt_fill = PCFP_ONE;
        end
      end
      PCFP_ONE:
      begin
        if (push && pop)
          nxt_head = in_word;
        else if (push)
        begin
          nxt_tail = in_word;
          nxt_fill = PCFP_FULL;
        end
        else if (pop)
          nxt_fill = PCFP_EMPTY;
      end
      PCFP_FULL:
      begin
        if (pop)
        begin
          nxt_head = tail_ff;
          nxt_fill = PCFP_ONE;
        end
      end
      default:
        nxt_fill = PCFP_EMPTY;
    endcase
    if (!nrst || srst)
    begin
      nxt_fill = PCFP_EMPTY;
      nxt_head = PCFP_WORD_RST;
      nxt_tail = PCFP_WORD_RST;
    end
    nxt_in_ready = (nxt_fill != PCFP_FULL);
    nxt_out_valid = (nxt_fill != PCFP_EMPTY);
    // write while full or read while empty
    nxt_fault = (in_valid && !in_ready_ff) || (out_ready && !out_valid_ff);
    if (!nrst || srst)
      nxt_fault = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    fill_ff <= nxt_fill;
    head_ff <= nxt_head;
    tail_ff <= nxt_tail;
    in_ready_ff <= nxt_in_ready;
    out_valid_ff <= nxt_out_valid;
    fault_ff <= nxt_fault;
  end

  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_word = head_ff;
  assign fault = fault_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_full;
    in_valid && !in_ready_ff;
  endsequence

  sequence s_read_empty;
    out_ready && !out_valid_ff;
  endsequence

  AST_OVF_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    (s_write_full and !srst) |=> fault_ff)
    else $error("write while full not flagged");

  AST_UNF_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    (s_read_empty and !srst) |=> fault_ff)
    else $error("read while empty not flagged");

  AST_NO_FALSE_FAULT: assert property (@(posedge clk) disable iff (!nrst)
    (!(in_valid && !in_ready_ff) && !(out_ready && !out_valid_ff)) |=> !fault_ff)
    else $error("fault without cause");

  AST_DIG_RESET: assert property (@(posedge clk) disable iff (!nrst)
    srst |=> (!out_valid_ff && in_ready_ff && !fault_ff))
    else $error("digital reset did not empty buffer");

  AST_FILL_TWO: assert property (@(posedge clk) disable iff (!nrst)
    (fill_ff == PCFP_EMPTY && !srst) ##1 (push && !pop && !srst)
      ##1 (push && !pop && !srst) |=> !in_ready_ff)
    else $error("buffer accepts beyond two words");

  AST_HOLD_STALL: assert property (@(posedge clk) disable iff (!nrst)
    (out_valid_ff && !out_ready && !srst) |=> (out_valid_ff && $stable(head_ff)))
    else $error("stalled word lost");
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module pcfp_top
  import pcfp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic gig_eth_mode,
  input wire logic rx_digital_reset,
  input wire logic tx_digital_reset,
  input wire logic rx_core_clk_sel,
  input wire logic tx_core_clk_sel,
  input wire pcfp_pkg::pcfp_word_t rx_pcs_word,
  input wire logic rx_pcs_valid,
  output logic rx_pcs_ready,
  output pcfp_pkg::pcfp_word_t rx_user_word,
  output logic rx_user_valid,
  input wire logic rx_xcvr_read,
  input wire logic rx_core_read,
  input wire pcfp_pkg::pcfp_word_t tx_xcvr_word,
  input wire logic tx_xcvr_valid,
  input wire pcfp_pkg::pcfp_word_t tx_core_word,
  input wire logic tx_core_valid,
  output logic tx_user_ready,
  output pcfp_pkg::pcfp_word_t tx_pcs_word,
  output logic tx_pcs_valid,
  input wire logic tx_pcs_ready,
  output logic rx_fifo_fault,
  output logic tx_fifo_fault,
  output logic rx_signal_detect
);
  import pcfp_pkg::*;

  logic rx_read;
  pcfp_word_t tx_in_word;
  logic tx_in_valid;
  logic sigdet_ff, nxt_sigdet;

  // ----------------------------------------
  // fabric side source selection
  // ----------------------------------------
  always_comb
  begin
    rx_read = rx_core_clk_sel ? rx_core_read : rx_xcvr_read;
    tx_in_word = tx_core_clk_sel ? tx_core_word : tx_xcvr_word;
    tx_in_valid = tx_core_clk_sel ? tx_core_valid : tx_xcvr_valid;
  end

  // ----------------------------------------
  // receive and transmit buffers
  // ----------------------------------------
  pcfp_fifo u_rx_fifo (
    .clk(clk),
    .nrst(nrst),
    .srst(rx_digital_reset),
    .in_word(rx_pcs_word),
    .in_valid(rx_pcs_valid),
    .in_ready(rx_pcs_ready),
    .out_word(rx_user_word),
    .out_valid(rx_user_valid),
    .out_ready(rx_read),
    .fault(rx_fifo_fault)
  );

  pcfp_fifo u_tx_fifo (
    .clk(clk),
    .nrst(nrst),
    .srst(tx_digital_reset),
    .in_word(tx_in_word),
    .in_valid(tx_in_valid),
    .in_ready(tx_user_ready),
    .out_word(tx_pcs_word),
    .out_valid(tx_pcs_valid),
    .out_ready(tx_pcs_ready),
    .fault(tx_fifo_fault)
  );

  // ----------------------------------------
  // forced signal detection, no presence output
  // ----------------------------------------
  always_comb
  begin
    nxt_sigdet = gig_eth_mode ? PCFP_SIGDET_FORCED : sigdet_ff;
    if (!nrst || rx_digital_reset)
      nxt_sigdet = PCFP_SIGDET_RST;
  end

  always_ff @(posedge clk)
  begin
    sigdet_ff <= nxt_sigdet;
  end

  assign rx_signal_detect = sigdet_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SIGDET_FORCED: assert property (@(posedge clk) disable iff (!nrst)
    (gig_eth_mode && !rx_digital_reset) [*2] |-> rx_signal_detect)
    else $error("signal detect not forced");

  AST_RX_SEL: assert property (@(posedge clk) disable iff (!nrst)
    (rx_core_clk_sel && !rx_core_read && rx_user_valid && !rx_digital_reset)
      |=> (rx_user_valid && $stable(rx_user_word)))
    else $error("receive read not taken from fabric request");

  AST_TX_SEL: assert property (@(posedge clk) disable iff (!nrst)
    (tx_core_clk_sel && tx_core_valid && tx_user_ready && !tx_digital_reset)
      |=> tx_pcs_valid)
    else $error("transmit write not taken from fabric source");

  AST_TX_RESET: assert property (@(posedge clk) disable iff (!nrst)
    tx_digital_reset |=> (!tx_pcs_valid && !tx_fifo_fault))
    else $error("transmit digital reset ineffective");
endmodule

// >>> testbench/pcfp_fabric_model.sv
/*
  pcfp_fabric_model: fabric user logic that reads the receive buffer and feeds transmit words.
  assumes it shares clk with the buffers.
*/
`timescale 1ns/1ns

module pcfp_fabric_model
  import pcfp_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic send,
  input wire pcfp_pkg::pcfp_word_t send_word,
  output logic rx_core_read,
  output pcfp_pkg::pcfp_word_t tx_core_word,
  output logic tx_core_valid
);
  pcfp_word_t last_ff = 9'h0AA;
  // one clock for both sides, no frequency offset
  // fault flags are left unused here
  assign rx_core_read = !stall;
  assign tx_core_valid = send;
  assign tx_core_word = send ? send_word : ~last_ff;
  always_ff @(posedge clk)
  begin
    last_ff <= tx_core_word;
  end
endmodule

// >>> testbench/testbench.sv
/*
  testbench: directed tests of the phase compensation fifo pair.
  assumes pcfp_pkg and pcfp_top are compiled first.
*/
`timescale 1ns/1ns

module testbench;
  import pcfp_pkg::*;
  logic clk, nrst, mode, rx_dr, tx_dr, rx_sel, tx_sel, rx_v, rx_xr, tx_xv, tx_rdy;
  logic stall, send, rx_rdy, rx_uv, tx_urdy, tx_pv, rx_flt, tx_flt, sigdet, rx_cr, tx_cv;
  pcfp_word_t rx_w, tx_xw, send_w, rx_uw, tx_pw, tx_cw;
  int n_errors = 0;
  int checks = 0;

  pcfp_fabric_model fab_u (.clk(clk), .stall(stall), .send(send), .send_word(send_w),
    .rx_core_read(rx_cr), .tx_core_word(tx_cw), .tx_core_valid(tx_cv));
  pcfp_top dut_u (.clk(clk), .nrst(nrst), .gig_eth_mode(mode), .rx_digital_reset(rx_dr),
    .tx_digital_reset(tx_dr), .rx_core_clk_sel(rx_sel), .tx_core_clk_sel(tx_sel),
    .rx_pcs_word(rx_w), .rx_pcs_valid(rx_v), .rx_pcs_ready(rx_rdy), .rx_user_word(rx_uw),
    .rx_user_valid(rx_uv), .rx_xcvr_read(rx_xr), .rx_core_read(rx_cr),
    .tx_xcvr_word(tx_xw), .tx_xcvr_valid(tx_xv), .tx_core_word(tx_cw),
    .tx_core_valid(tx_cv), .tx_user_ready(tx_urdy), .tx_pcs_word(tx_pw),
    .tx_pcs_valid(tx_pv), .tx_pcs_ready(tx_rdy), .rx_fifo_fault(rx_flt),
    .tx_fifo_fault(tx_flt), .rx_signal_detect(sigdet));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task step;
    @(posedge clk);
    #1;
  endtask

  task chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp)
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    if (seen !== exp)
      n_errors++;
  endtask

  task fault2(input logic tx, input logic exp_now, input logic exp_next);
    chk(9'(tx ? tx_flt : rx_flt), 9'(exp_now));
    step();
    chk(9'(tx ? tx_flt : rx_flt), 9'(exp_next));
  endtask

  task results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_rx;
    rx_v = 1;
    rx_w = 9'h1A5;
    step();
    rx_w = 9'h03C;
    step();
    rx_w = 9'h0FF;
    step();
    rx_v = 0;
    fault2(0, 1, 0);
    chk(9'(rx_rdy), 9'h000);
    chk(rx_uw, 9'h1A5);
    stall = 0;
    step();
    chk(rx_uw, 9'h03C);
    step();
    chk(9'(rx_uv), 9'h000);
    fault2(0, 0, 1);
    stall = 1;
    $display("test rx done");
  endtask

  task t_tx;
    tx_xv = 1;
    tx_xw = 9'h033;
    send = 1;
    send_w = 9'h15A;
    step();
    send = 0;
    step();
    chk(tx_pw, 9'h15A);
    chk(9'(tx_pv), 9'h001);
    tx_rdy = 1;
    step();
    chk(9'(tx_pv), 9'h000);
    fault2(1, 0, 1);
    tx_rdy = 0;
    tx_xv = 0;
    $display("test tx done");
  endtask

  task t_xcvr;
    {rx_sel, tx_sel, rx_xr, stall} = '0;
    rx_v = 1;
    rx_w = 9'h055;
    tx_xv = 1;
    tx_xw = 9'h0C3;
    send = 1;
    send_w = 9'h13C;
    step();
    {rx_v, tx_xv, send} = '0;
    step();
    chk(rx_uw, 9'h055);
    chk(9'(rx_uv), 9'h001);
    chk(tx_pw, 9'h0C3);
    rx_xr = 1;
    tx_xv = 1;
    tx_xw = 9'h0E1;
    step();
    chk(9'(rx_uv), 9'h000);
    rx_xr = 0;
    tx_xw = 9'h0F0;
    chk(9'(tx_urdy), 9'h000);
    fault2(1, 0, 1);
    tx_xv = 0;
    tx_rdy = 1;
    step();
    chk(tx_pw, 9'h0E1);
    step();
    chk(9'(tx_pv), 9'h000);
    tx_rdy = 0;
    stall = 1;
    $display("test xcvr done");
  endtask

  task t_rst;
    rx_v = 1;
    send = 1;
    step();
    rx_v = 0;
    send = 0;
    rx_dr = 1;
    tx_dr = 1;
    step();
    chk({rx_uv, rx_rdy, tx_pv, tx_urdy, sigdet}, 9'h00A);
    mode = 0;
    rx_dr = 0;
    tx_dr = 0;
    step();
    chk(9'(sigdet), 9'h000);
    mode = 1;
    step();
    chk(9'(sigdet), 9'h001);
    $display("test reset done");
  endtask

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #20000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    {nrst, rx_dr, tx_dr, rx_v, tx_xv, tx_rdy, send} = '0;
    {mode, rx_sel, tx_sel, rx_xr, stall} = '1;
    {rx_w, tx_xw, send_w} = '0;
    repeat (2) step();
    nrst = 1;
    step();
    chk({sigdet, rx_rdy, rx_uv}, 9'h006);
    t_rx();
    t_tx();
    t_rst();
    t_xcvr();
    results();
  end
endmodule
